// File: hw/async_timer.sv
// Asynchronous timer: clock select, prescaler, shadowed writes, flag sync and channel A output
// Operation
// - Async writes wait in a temporary register for two oscillator rising edges
// - Each of five shadowed registers has its own temporary register
// - Busy flag per register while transfer pending; software waits for clear
// - Compare match suppressed while count or compare write is pending
// - Wake-up starts on the timer tick after the interrupt condition
// - Count reads use a copy refreshed each oscillator rise (each system cycle in sync mode), frozen in sleep
// - Async flags reach software after three system cycles plus a timer cycle
// - Compare output changes on the timer tick, not resynchronised
// - Source defaults to system clock; async select switches to oscillator pin
// - Async select detaches both oscillator pins from port function
// - Prescaler gives divide by 8,32,64,128,256,1024, undivided and stop
// - Prescaler reset bit puts the prescaler into a defined state
// - Nonzero channel A mode routes compare output over the port pin
// - Non-PWM modes: off, toggle, clear or set on match
// - Fast PWM: clear/set on match, inverse at bottom; toggle needs high bit
// - Fast PWM with compare at top and mode bit 1: act only at bottom
// - Phase PWM: clear up-match, set down-match or reverse; toggle needs high bit
// - Phase PWM with compare at top and mode bit 1: act only at top
// - Control A holds modes at 7:6, 5:4, wave bits 1:0, reset zero
// - Oscillator stops only in power-down and standby; the code also stops it (oscEnable low) whenever async select is clear
// - Wave mode decode: normal, phase, CTC, fast; codes 4 and 6 reserved
// - Clock select decode: stop, undivided, then 8 through 1024
//
// Register access over AHB-Lite was chosen for this implementation.
module async_timer (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Oscillator pin and sleep control
   input wire logic oscInPin,
   input wire logic sleepActive,
   input wire logic deepSleep,
   output logic oscEnable,
   output logic oscPinsDetached,
   output logic wakeRequest,
   // Channel A compare output
   output logic compareOutA,
   output logic compareOutAOverride
);
   import async_timer_pkg::*;

   logic [1:0] rstSync;
   logic rstN;
   logic [1:0] oscSync;
   logic oscLast;
   logic oscRise;
   logic dataPhase;
   logic dataWrite;
   logic [7:0] dataAddr;
   logic [7:0] controlA;
   logic [7:0] controlB;
   logic [7:0] count;
   logic [7:0] compareA;
   logic [7:0] compareB;
   logic asyncSelect;
   logic prescReset;
   logic [2:0] flags;
   logic [2:0] irqEnable;
   logic [7:0] shadow [SLOT_NUM];
   logic [SLOT_NUM-1:0] busy;
   logic [1:0] edgeCount [SLOT_NUM];
   logic [SLOT_NUM-1:0] slotWrite;
   logic [SLOT_NUM-1:0] slotDone;
   logic [9:0] presc;
   logic srcTick;
   logic timerTick;
   logic [2:0] waveMode;
   logic [1:0] modeA;
   logic [7:0] top;
   logic matchA;
   logic matchB;
   logic atTop;
   logic [2:0] rawEvent;
   logic [2:0] flagPipe [FLAG_SYNC_CYCLES];
   logic [2:0] flagSet;
   logic [2:0] flagClear;
   logic [7:0] countCopy;
   logic [7:0] readByte;
   count_dir_type dir;

   // Prescaler tap for a clock select code; code 0 stops the timer
   function automatic logic divReady(input logic [2:0] code, input logic [9:0] p);
      logic r;
      r = 1'b0;
      unique case (code)
         3'h0: r = 1'b0;
         3'h1: r = 1'b1;
         3'h2: r = &p[2:0];
         3'h3: r = &p[4:0];
         3'h4: r = &p[5:0];
         3'h5: r = &p[6:0];
         3'h6: r = &p[7:0];
         3'h7: r = &p[9:0];
      endcase
      return r;
   endfunction

   // Output action for a mode code: toggle, clear or set
   function automatic logic applyMode(input logic [1:0] mode, input logic cur);
      logic r;
      r = cur;
      unique case (mode)
         OUT_OFF: r = cur;
         OUT_TOGGLE: r = ~cur;
         OUT_CLEAR: r = 1'b0;
         OUT_SET: r = 1'b1;
      endcase
      return r;
   endfunction

   // Reset release through two flops
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rstSync <= 2'b00;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end
   assign rstN = rstSync[1];

   // Oscillator pin synchroniser; only the second stage is read
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         oscSync <= 2'b00;
         oscLast <= 1'b0;
      end else begin
         oscSync <= {oscSync[0], oscInPin};
         oscLast <= oscSync[1];
      end
   end
   assign oscRise = oscSync[1] & ~oscLast;

   // Source clock tick: every system cycle by default, oscillator edge when async
   assign srcTick = asyncSelect ? oscRise : 1'b1;
   assign oscPinsDetached = asyncSelect;
   assign oscEnable = asyncSelect & ~deepSleep;

   // Bus address phase capture
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         dataPhase <= 1'b0;
         dataWrite <= 1'b0;
         dataAddr <= 8'h00;
      end else if (hready) begin
         dataPhase <= hsel & htrans[1];
         dataWrite <= hsel & htrans[1] & hwrite;
         dataAddr <= haddr[7:0];
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Write strobes per shadowed register
   always_comb begin
      slotWrite = '0;
      if (dataWrite) begin
         slotWrite[SLOT_CONTROL_A] = (dataAddr == TIMER2_CONTROL_A_ADDR);
         slotWrite[SLOT_CONTROL_B] = (dataAddr == TIMER2_CONTROL_B_ADDR);
         slotWrite[SLOT_COUNT] = (dataAddr == COUNT_VALUE_ADDR);
         slotWrite[SLOT_COMPARE_A] = (dataAddr == COMPARE_A_ADDR);
         slotWrite[SLOT_COMPARE_B] = (dataAddr == COMPARE_B_ADDR);
      end
   end

   // Temporary registers and busy tracking, one independent slot each
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         for (int i = 0; i < SLOT_NUM; i++) begin
            shadow[i] <= 8'h00;
            edgeCount[i] <= 2'h0;
         end
         busy <= '0;
      end else begin
         for (int i = 0; i < SLOT_NUM; i++) begin
            if (slotWrite[i]) begin
               shadow[i] <= hwdata[7:0];
               edgeCount[i] <= 2'h0;
               busy[i] <= asyncSelect;
            end else if (busy[i] && oscRise) begin
               if (edgeCount[i] + 2'h1 == TRANSFER_EDGES) begin
                  busy[i] <= 1'b0;
               end
               edgeCount[i] <= edgeCount[i] + 2'h1;
            end
         end
      end
   end

   // A slot lands either at once in sync mode or on its second oscillator edge
   always_comb begin
      for (int i = 0; i < SLOT_NUM; i++) begin
         slotDone[i] = (slotWrite[i] & ~asyncSelect) |
                       (~slotWrite[i] & busy[i] & oscRise & (edgeCount[i] + 2'h1 == TRANSFER_EDGES));
      end
   end

   // Destination registers take the written or shadowed value
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         controlA <= CONTROL_A_RESET;
         controlB <= CONTROL_B_RESET;
         compareA <= 8'h00;
         compareB <= 8'h00;
      end else begin
         if (slotDone[SLOT_CONTROL_A]) begin
            controlA <= (asyncSelect ? shadow[SLOT_CONTROL_A] : hwdata[7:0]) & CONTROL_A_MASK;
         end
         if (slotDone[SLOT_CONTROL_B]) begin
            controlB <= (asyncSelect ? shadow[SLOT_CONTROL_B] : hwdata[7:0]) & CONTROL_B_MASK;
         end
         if (slotDone[SLOT_COMPARE_A]) begin
            compareA <= asyncSelect ? shadow[SLOT_COMPARE_A] : hwdata[7:0];
         end
         if (slotDone[SLOT_COMPARE_B]) begin
            compareB <= asyncSelect ? shadow[SLOT_COMPARE_B] : hwdata[7:0];
         end
      end
   end

   // Direct registers: async select, prescaler reset strobe, enables
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         asyncSelect <= 1'b0;
         prescReset <= 1'b0;
         irqEnable <= 3'h0;
      end else begin
         prescReset <= dataWrite && (dataAddr == GENERAL_CONTROL_ADDR) && hwdata[PRESCALER_RESET_BIT];
         if (dataWrite && dataAddr == ASYNC_STATUS_ADDR) begin
            asyncSelect <= hwdata[ASYNC_SELECT_BIT];
         end
         if (dataWrite && dataAddr == IRQ_ENABLE_ADDR) begin
            irqEnable <= hwdata[2:0];
         end
      end
   end

   // Prescaler, counts source ticks; reset bit clears it
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         presc <= 10'h000;
      end else if (prescReset) begin
         presc <= 10'h000;
      end else if (srcTick) begin
         presc <= presc + 10'h001;
      end
   end
   assign timerTick = srcTick & divReady(controlB[2:0], presc);

   // Mode decode and compare; matches are blocked while a count or compare write is in flight
   assign waveMode = {controlB[WAVE_HIGH_BIT], controlA[1:0]};
   assign modeA = controlA[CHAN_A_MODE_LSB +: 2];
   assign top = (waveMode == WAVE_CTC || waveMode == WAVE_PHASE_CMP || waveMode == WAVE_FAST_CMP) ?
                compareA : COUNT_MAX;
   assign atTop = (count == top);
   assign matchA = (count == compareA) & ~busy[SLOT_COUNT] & ~busy[SLOT_COMPARE_A];
   assign matchB = (count == compareB) & ~busy[SLOT_COUNT] & ~busy[SLOT_COMPARE_B];

   // Counter and direction
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         count <= 8'h00;
         dir <= COUNT_UP;
      end else if (slotDone[SLOT_COUNT]) begin
         count <= asyncSelect ? shadow[SLOT_COUNT] : hwdata[7:0];
      end else if (timerTick) begin
         unique case (waveMode)
            WAVE_PHASE_FF, WAVE_PHASE_CMP: begin
               if (dir == COUNT_UP && atTop) begin
                  dir <= COUNT_DOWN;
                  count <= count - 8'h01;
               end else if (dir == COUNT_DOWN && count == COUNT_BOTTOM) begin
                  dir <= COUNT_UP;
                  count <= count + 8'h01;
               end else begin
                  count <= (dir == COUNT_UP) ? count + 8'h01 : count - 8'h01;
               end
            end
            WAVE_CTC, WAVE_FAST_FF, WAVE_FAST_CMP: begin
               count <= atTop ? COUNT_BOTTOM : count + 8'h01;
               dir <= COUNT_UP;
            end
            default: begin
               // Normal and reserved codes count freely
               count <= count + 8'h01;
               dir <= COUNT_UP;
            end
         endcase
      end
   end

   // Raw timer events in the timer tick
   always_comb begin
      rawEvent = 3'h0;
      if (timerTick) begin
         rawEvent[FLAG_COMPARE_A] = matchA;
         rawEvent[FLAG_COMPARE_B] = matchB;
         if (waveMode == WAVE_PHASE_FF || waveMode == WAVE_PHASE_CMP) begin
            rawEvent[FLAG_OVERFLOW] = (dir == COUNT_DOWN) && (count == COUNT_BOTTOM);
         end else if (waveMode == WAVE_FAST_CMP) begin
            rawEvent[FLAG_OVERFLOW] = atTop;
         end else begin
            rawEvent[FLAG_OVERFLOW] = (count == COUNT_MAX);
         end
      end
   end

   // Channel A output, updated straight on the timer tick
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         compareOutA <= 1'b0;
      end else if (timerTick) begin
         unique case (waveMode)
            WAVE_FAST_FF, WAVE_FAST_CMP: begin
               if (atTop && modeA[1]) begin
                  compareOutA <= ~modeA[0];
               end else if (matchA && !(compareA == top && modeA[1])) begin
                  if (modeA == OUT_TOGGLE) begin
                     compareOutA <= controlB[WAVE_HIGH_BIT] ? ~compareOutA : compareOutA;
                  end else begin
                     compareOutA <= applyMode(modeA, compareOutA);
                  end
               end
            end
            WAVE_PHASE_FF, WAVE_PHASE_CMP: begin
               if (compareA == top && modeA[1]) begin
                  if (atTop) begin
                     compareOutA <= ~modeA[0];
                  end
               end else if (matchA) begin
                  if (modeA == OUT_TOGGLE) begin
                     compareOutA <= controlB[WAVE_HIGH_BIT] ? ~compareOutA : compareOutA;
                  end else if (modeA[1]) begin
                     compareOutA <= (dir == COUNT_UP) ? modeA[0] : ~modeA[0];
                  end
               end
            end
            default: begin
               if (matchA) begin
                  compareOutA <= applyMode(modeA, compareOutA);
               end
            end
         endcase
      end
   end
   assign compareOutAOverride = |modeA;

   // Flag synchroniser; bypassed when the timer runs on the system clock
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         for (int i = 0; i < FLAG_SYNC_CYCLES; i++) begin
            flagPipe[i] <= 3'h0;
         end
      end else begin
         flagPipe[0] <= rawEvent;
         for (int i = 1; i < FLAG_SYNC_CYCLES; i++) begin
            flagPipe[i] <= flagPipe[i-1];
         end
      end
   end
   assign flagSet = asyncSelect ? flagPipe[FLAG_SYNC_CYCLES-1] : rawEvent;
   assign flagClear = (dataWrite && dataAddr == FLAGS_ADDR) ? hwdata[2:0] : 3'h0;

   // Sticky flags, a set in the clearing cycle survives
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         flags <= 3'h0;
      end else begin
         flags <= (flags & ~flagClear) | flagSet;
      end
   end

   // Wake request goes out on the timer tick after an enabled condition
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         wakeRequest <= 1'b0;
      end else if (!sleepActive) begin
         wakeRequest <= 1'b0;
      end else if (timerTick && |(flags & irqEnable)) begin
         wakeRequest <= 1'b1;
      end
   end

   // Count copy for reads, frozen while the system clock sleeps
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         countCopy <= 8'h00;
      end else if (!sleepActive && (asyncSelect ? oscRise : 1'b1)) begin
         countCopy <= count;
      end
   end

   // Read mux; unmapped reads give zero
   always_comb begin
      unique case (haddr[7:0])
         TIMER2_CONTROL_A_ADDR: readByte = controlA;
         TIMER2_CONTROL_B_ADDR: readByte = controlB;
         COUNT_VALUE_ADDR: readByte = countCopy;
         COMPARE_A_ADDR: readByte = compareA;
         COMPARE_B_ADDR: readByte = compareB;
         ASYNC_STATUS_ADDR: readByte = {2'b00, asyncSelect, busy};
         FLAGS_ADDR: readByte = {5'b00000, flags};
         IRQ_ENABLE_ADDR: readByte = {5'b00000, irqEnable};
         default: readByte = 8'h00;
      endcase
   end

   // Read data latched at the address phase
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         hrdata <= {24'h00_0000, readByte};
      end
   end
endmodule

// File: hw/async_timer_pkg.sv
// Constants for the asynchronous timer: register map, fields, modes and timing
package async_timer_pkg;
   // Register byte addresses
   localparam logic [7:0] TIMER2_CONTROL_A_ADDR = 8'hb0;
   localparam logic [7:0] TIMER2_CONTROL_B_ADDR = 8'hb4;
   localparam logic [7:0] COUNT_VALUE_ADDR = 8'hb8;
   localparam logic [7:0] COMPARE_A_ADDR = 8'hbc;
   localparam logic [7:0] COMPARE_B_ADDR = 8'hc0;
   localparam logic [7:0] ASYNC_STATUS_ADDR = 8'hc4;
   localparam logic [7:0] GENERAL_CONTROL_ADDR = 8'hc8;
   localparam logic [7:0] FLAGS_ADDR = 8'hcc;
   localparam logic [7:0] IRQ_ENABLE_ADDR = 8'hd0;
   // Reset values
   localparam logic [7:0] CONTROL_A_RESET = 8'h00;
   localparam logic [7:0] CONTROL_B_RESET = 8'h00;
   localparam logic [7:0] CONTROL_A_MASK = 8'hf3;
   localparam logic [7:0] CONTROL_B_MASK = 8'h0f;
   // Field positions
   localparam int CHAN_A_MODE_LSB = 6;
   localparam int CHAN_B_MODE_LSB = 4;
   localparam int WAVE_HIGH_BIT = 3;
   localparam int ASYNC_SELECT_BIT = 5;
   localparam int PRESCALER_RESET_BIT = 1;
   localparam int FLAG_OVERFLOW = 0;
   localparam int FLAG_COMPARE_A = 1;
   localparam int FLAG_COMPARE_B = 2;
   // Index of each shadowed register, also its busy bit in the status register
   localparam int SLOT_CONTROL_B = 0;
   localparam int SLOT_CONTROL_A = 1;
   localparam int SLOT_COMPARE_B = 2;
   localparam int SLOT_COMPARE_A = 3;
   localparam int SLOT_COUNT = 4;
   localparam int SLOT_NUM = 5;
   // Wave mode codes
   localparam logic [2:0] WAVE_NORMAL = 3'h0;
   localparam logic [2:0] WAVE_PHASE_FF = 3'h1;
   localparam logic [2:0] WAVE_CTC = 3'h2;
   localparam logic [2:0] WAVE_FAST_FF = 3'h3;
   localparam logic [2:0] WAVE_PHASE_CMP = 3'h5;
   localparam logic [2:0] WAVE_FAST_CMP = 3'h7;
   localparam logic [7:0] COUNT_MAX = 8'hff;
   localparam logic [7:0] COUNT_BOTTOM = 8'h00;
   // Output mode codes
   localparam logic [1:0] OUT_OFF = 2'h0;
   localparam logic [1:0] OUT_TOGGLE = 2'h1;
   localparam logic [1:0] OUT_CLEAR = 2'h2;
   localparam logic [1:0] OUT_SET = 2'h3;
   // Timing
   localparam logic [1:0] TRANSFER_EDGES = 2'h2;
   localparam int FLAG_SYNC_CYCLES = 3;
   typedef enum logic [1:0] {COUNT_UP = 2'b01, COUNT_DOWN = 2'b10} count_dir_type;
endpackage

// File: verification/async_timer_monitor.sv
// Port checker for the asynchronous timer, bound to its top module
module async_timer_monitor (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Register bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // Sleep, oscillator and output
   input wire logic sleepActive,
   input wire logic deepSleep,
   input wire logic oscEnable,
   input wire logic oscPinsDetached,
   input wire logic wakeRequest,
   input wire logic compareOutAOverride
);
   timeunit 1ns;
   timeprecision 1ns;
   import async_timer_pkg::*;
   logic dpWrite;
   logic dpRead;
   logic [7:0] dpAddr;
   // Data phase tracking, so checks land on the cycle the write takes effect
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         dpWrite <= 1'b0;
         dpRead <= 1'b0;
         dpAddr <= 8'h00;
      end else begin
         dpWrite <= hsel && hready && htrans[1] && hwrite;
         dpRead <= hsel && hready && htrans[1] && !hwrite;
         dpAddr <= haddr[7:0];
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   a_osc_enable: assert property (oscEnable == (oscPinsDetached && !deepSleep))
      else $error("oscillator enable wrong");
   a_detach_write: assert property (dpWrite && dpAddr == ASYNC_STATUS_ADDR
      |=> oscPinsDetached == $past(hwdata[ASYNC_SELECT_BIT])) else $error("pin detach not following write");
   a_detach_hold: assert property (!(dpWrite && dpAddr == ASYNC_STATUS_ADDR)
      |=> $stable(oscPinsDetached)) else $error("pin detach changed without write");
   a_override_sync: assert property (dpWrite && dpAddr == TIMER2_CONTROL_A_ADDR && !oscPinsDetached
      |=> compareOutAOverride == ($past(hwdata[7:6]) != 2'b00)) else $error("override wrong");
   a_override_async: assert property (dpWrite && dpAddr == TIMER2_CONTROL_A_ADDR && oscPinsDetached
      |=> $stable(compareOutAOverride)) else $error("async write took effect at once");
   a_ctrl_gap: assert property (dpRead && dpAddr == TIMER2_CONTROL_A_ADDR |-> hrdata[3:2] == 2'b00)
      else $error("control a unused bits nonzero");
   a_presc_zero: assert property (dpRead && dpAddr == GENERAL_CONTROL_ADDR |-> hrdata == 32'h0000_0000)
      else $error("prescaler reset strobe reads nonzero");
   a_wake_clear: assert property (!sleepActive |=> !wakeRequest)
      else $error("wake request outside sleep");
   a_wake_cause: assert property ($rose(wakeRequest) |-> $past(sleepActive))
      else $error("wake request rose while awake");
endmodule
bind async_timer async_timer_monitor async_timer_monitor_i (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .sleepActive(sleepActive), .deepSleep(deepSleep), .oscEnable(oscEnable), .oscPinsDetached(oscPinsDetached),
   .wakeRequest(wakeRequest), .compareOutAOverride(compareOutAOverride));

// File: verification/osc_crystal_model.sv
// Crystal on the timer oscillator pins, a square wave gated by the enable
module osc_crystal_model #(
   // Odd half period keeps the phase unrelated to the system clock
   parameter int HALF_NS = 213
) (
   // Oscillator control and output
   input wire logic oscEnable,
   output logic oscInPin
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      oscInPin = 1'b0;
      forever begin
         #HALF_NS;
         // Crystal stops dead when the device disables it
         oscInPin = oscEnable ? ~oscInPin : 1'b0;
      end
   end
endmodule

// File: verification/async_timer_tb_top.sv
// Self-checking testbench for the asynchronous timer
module async_timer_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import async_timer_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic sleepActive = 1'b0;
   logic deepSleep = 1'b0;
   logic hreadyout, hresp, oscInPin, oscEnable, oscPinsDetached, wakeRequest, compareOutA, compareOutAOverride;
   logic [31:0] hrdata, rd, wd, cnt;
   int errorCnt = 0;
   int compares = 0;
   int cyc = 0;
   int t0, ones;
   int expReg[int];
   int divs[8] = '{1, 1, 8, 32, 64, 128, 256, 1024};
   int tw[9] = '{0, 0, 0, 3, 3, 1, 1, 3, 1};
   int tm[9] = '{3, 2, 1, 2, 3, 2, 3, 2, 2};
   int tc[9] = '{64, 64, 64, 64, 64, 64, 64, 255, 255};
   int tn[9] = '{256, 256, 512, 256, 256, 510, 510, 256, 510};
   int te[9] = '{256, 0, 256, 65, 191, 128, 382, 256, 510};
   always #25 clk_sys = ~clk_sys;
   // Hang guard, well above the planned run length
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         errorCnt++;
         completeRun();
      end
   end
   async_timer async_timer_i (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .oscInPin(oscInPin), .sleepActive(sleepActive), .deepSleep(deepSleep),
      .oscEnable(oscEnable), .oscPinsDetached(oscPinsDetached), .wakeRequest(wakeRequest),
      .compareOutA(compareOutA), .compareOutAOverride(compareOutAOverride));
   osc_crystal_model osc_crystal_model_i (.oscEnable(oscEnable), .oscInPin(oscInPin));
   task automatic check(input string name, input int lo, input int hi, input logic [31:0] got);
      compares++;
      if ($isunknown(got) || got < lo || got > hi) begin
         errorCnt++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi, got);
      end
   endtask
   task automatic busXfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= 32'(a);
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      q = hrdata;
      check("hresp", 0, 0, 32'(hresp));
   endtask
   task automatic writeReg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      busXfer(1'b1, a, d, q);
   endtask
   task automatic rdReg(input logic [7:0] a, output logic [31:0] q);
      busXfer(1'b0, a, 32'h0000_0000, q);
   endtask
   task automatic completeRun();
      $display("compares %0d mismatches %0d", compares, errorCnt);
      if (errorCnt == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      void'($urandom(11));
      repeat (10) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk_sys);
      // Reset values, strobe register and an unmapped place
      expReg.delete();
      rdReg(TIMER2_CONTROL_A_ADDR, rd);
      check("control a reset", 0, 0, rd);
      rdReg(ASYNC_STATUS_ADDR, rd);
      check("status reset", 0, 0, rd);
      rdReg(GENERAL_CONTROL_ADDR, rd);
      check("prescaler strobe", 0, 0, rd);
      rdReg(8'he0, rd);
      check("unmapped", 0, 0, rd);
      $display("reset test done");
      // Control A fields, every channel A mode once
      for (int i = 0; i < 4; i++) begin
         wd = {24'h00_0000, i[1:0], 6'($urandom)};
         expReg[TIMER2_CONTROL_A_ADDR] = int'(wd & 32'(CONTROL_A_MASK));
         writeReg(TIMER2_CONTROL_A_ADDR, wd);
         rdReg(TIMER2_CONTROL_A_ADDR, rd);
         check("control a", expReg[TIMER2_CONTROL_A_ADDR], expReg[TIMER2_CONTROL_A_ADDR], rd);
         check("override", i != 0, i != 0, 32'(compareOutAOverride));
      end
      $display("register test done");
      // Prescaler divide per clock select code, started from a reset prescaler
      writeReg(TIMER2_CONTROL_A_ADDR, 32'h0000_0000);
      for (int cs = 0; cs < 8; cs++) begin
         writeReg(TIMER2_CONTROL_B_ADDR, cs);
         writeReg(GENERAL_CONTROL_ADDR, 32'h0000_0002);
         writeReg(COUNT_VALUE_ADDR, 32'h0000_0000);
         repeat (16 * divs[cs] + 8) @(posedge clk_sys);
         rdReg(COUNT_VALUE_ADDR, rd);
         check("count", cs ? 16 : 0, cs ? 17 + 14 / divs[cs] : 0, rd);
      end
      $display("prescaler test done");
      // Output duty per wave and output mode, undivided clock
      writeReg(TIMER2_CONTROL_B_ADDR, 32'h0000_0001);
      for (int k = 0; k < 9; k++) begin
         writeReg(COMPARE_A_ADDR, tc[k]);
         writeReg(TIMER2_CONTROL_A_ADDR, tm[k] * 64 + tw[k]);
         repeat (600) @(posedge clk_sys);
         ones = 0;
         repeat (tn[k]) begin
            @(posedge clk_sys);
            if (compareOutA === 1'b1) ones++;
         end
         check("duty", te[k] > 4 ? te[k] - 4 : 0, te[k] + 4, ones);
      end
      $display("waveform test done");
      // Asynchronous clocking: shadowed writes, busy flags, detach
      writeReg(ASYNC_STATUS_ADDR, 32'h0000_0020);
      @(posedge clk_sys);
      check("detached", 1, 1, 32'(oscPinsDetached));
      t0 = cyc;
      writeReg(COMPARE_A_ADDR, 32'h0000_0033);
      writeReg(TIMER2_CONTROL_A_ADDR, 32'h0000_0080);
      rdReg(ASYNC_STATUS_ADDR, rd);
      check("busy pair", 32'h2a, 32'h2a, rd);
      do rdReg(ASYNC_STATUS_ADDR, rd); while (rd[4:0] !== 5'h00);
      check("transfer time", 11, 40, cyc - t0);
      rdReg(TIMER2_CONTROL_A_ADDR, rd);
      check("control a async", 32'h80, 32'h80, rd);
      // Wake from sleep on overflow; count copy frozen while asleep
      writeReg(FLAGS_ADDR, 32'h0000_0007);
      writeReg(IRQ_ENABLE_ADDR, 32'h0000_0001);
      writeReg(COUNT_VALUE_ADDR, 32'h0000_00f0);
      do rdReg(ASYNC_STATUS_ADDR, rd); while (rd[4] !== 1'b0);
      sleepActive <= 1'b1;
      t0 = cyc;
      while (wakeRequest !== 1'b1 && cyc - t0 < 2000) @(posedge clk_sys);
      check("wake", 1, 1, 32'(wakeRequest));
      rdReg(COUNT_VALUE_ADDR, cnt);
      repeat (40) @(posedge clk_sys);
      rdReg(COUNT_VALUE_ADDR, rd);
      check("frozen count", cnt, cnt, rd);
      sleepActive <= 1'b0;
      repeat (40) @(posedge clk_sys);
      rdReg(COUNT_VALUE_ADDR, rd);
      // Ticks since sleep entry at one oscillator rise per 426 ns, modulo the 8-bit count
      check("count resumed", (cyc - t0) * 50 / 426 - 2, (cyc - t0) * 50 / 426 + 2, (rd - cnt) & 32'h0000_00ff);
      deepSleep <= 1'b1;
      repeat (2) @(posedge clk_sys);
      check("osc stopped", 0, 0, 32'(oscEnable));
      deepSleep <= 1'b0;
      $display("async test done");
      completeRun();
   end
endmodule
